// >>> logic/analog_shared_gpio_ports.sv
// three shared analog / digital ports behind banked registers
// assumes a byte register port driven on clk and pins async to clk
`timescale 1ns/100ps
module analog_shared_gpio_ports
    import gpio_ports_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    // banked register port
    input wire logic [3:0] bankSelect,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // pins
    input wire logic [7:0] firstPinIn,
    output logic [7:0] firstPinOut,
    output logic [7:0] firstPinOe,
    input wire logic [7:0] secondPinIn,
    output logic [7:0] secondPinOut,
    output logic [7:0] secondPinOe,
    input wire logic [7:0] thirdPinIn,
    output logic [7:0] thirdPinOut,
    output logic [7:0] thirdPinOe,
    // converter side
    input wire logic vrefLowEnable,
    input wire logic vrefHighEnable,
    output logic [1:0] conversionClockSelect,
    output logic resultFormat,
    output logic [7:0] firstAnalogMask,
    output logic [7:0] secondAnalogMask,
    output logic [7:0] thirdAnalogMask,
    // capture and pulse side
    output logic thirdCaptureInput,
    input wire logic pulseEnable,
    input wire logic thirdPulseOutput,
    // second serial unit side
    input wire logic serialEnable,
    input wire logic serialDataOut,
    input wire logic serialDataOe,
    input wire logic serialClkOut,
    input wire logic serialClkOe,
    output logic serialDataIn,
    output logic serialClkIn
);

    ////////////////////////////////////////////////////////////////////////
    // address decode
    logic lowBank, highBank;
    logic hitFirstDir, hitFirstData, hitSecondDir, hitSecondData;
    logic hitCfg, hitThirdDir, hitThirdData;

    // bank choice is software's job; anything else is unmapped
    always_comb begin
        lowBank = bankSelect == BANK_LOW_PORTS;
        highBank = bankSelect == BANK_HIGH_PORT;
        hitFirstDir = lowBank && regAddr == OFS_FIRST_DIR;
        hitFirstData = lowBank && regAddr == OFS_FIRST_DATA;
        hitSecondDir = lowBank && regAddr == OFS_SECOND_DIR;
        hitSecondData = lowBank && regAddr == OFS_SECOND_DATA;
        hitCfg = lowBank && regAddr == OFS_ANALOG_CFG;
        hitThirdDir = highBank && regAddr == OFS_THIRD_DIR;
        hitThirdData = highBank && regAddr == OFS_THIRD_DATA;
    end

    ////////////////////////////////////////////////////////////////////////
    // analog configuration register
    logic [7:0] analogCfg_reg, analogCfg_next;
    logic [3:0] pinConfigField;

    always_comb begin
        analogCfg_next = analogCfg_reg;
        if (regWrite && hitCfg) begin
            analogCfg_next = regWrData & ANALOG_CFG_IMPL;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            // zero field leaves all 16 converter channel pins analog
            analogCfg_reg <= ANALOG_CFG_RESET;
        end else begin
            analogCfg_reg <= analogCfg_next;
        end
    end

    assign pinConfigField = analogCfg_reg[PIN_CFG_HI:PIN_CFG_LO];
    assign conversionClockSelect = analogCfg_reg[CLK_SEL_HI:CLK_SEL_LO];
    assign resultFormat = analogCfg_reg[RESULT_FMT_BIT];

    analog_channel_map channelMap (
        .pinConfigField(pinConfigField),
        .vrefLowEnable(vrefLowEnable),
        .vrefHighEnable(vrefHighEnable),
        .firstAnalog(firstAnalogMask),
        .secondAnalog(secondAnalogMask),
        .thirdAnalog(thirdAnalogMask)
    );

    ////////////////////////////////////////////////////////////////////////
    // alternate functions of the second port
    logic [7:0] secondDir, secondLatch, secondLevel, secondRead;
    logic [7:0] secondAltSel, secondAltOut, secondAltOe;

    always_comb begin
        secondAltSel = '0;
        secondAltOut = '0;
        secondAltOe = '0;
        // pulse output replaces the latch but still needs dir 0
        secondAltSel[PWM_BIT] = pulseEnable;
        secondAltOut[PWM_BIT] = thirdPulseOutput;
        secondAltOe[PWM_BIT] = ~secondDir[PWM_BIT];
        // serial unit owns both pins and their direction
        secondAltSel[SERIAL_RX_BIT] = serialEnable;
        secondAltOut[SERIAL_RX_BIT] = serialDataOut;
        secondAltOe[SERIAL_RX_BIT] = serialDataOe;
        secondAltSel[SERIAL_TX_BIT] = serialEnable;
        secondAltOut[SERIAL_TX_BIT] = serialClkOut;
        secondAltOe[SERIAL_TX_BIT] = serialClkOe;
    end

    ////////////////////////////////////////////////////////////////////////
    // the three ports
    logic [7:0] firstDir, firstLatch, firstLevel, firstRead;
    logic [7:0] thirdDir, thirdLatch, thirdLevel, thirdRead;

    gpio_port_slice firstPort (
        .clk(clk),
        .reset(reset),
        .dirWrite(regWrite && hitFirstDir),
        .latchWrite(regWrite && hitFirstData),
        .wrData(regWrData),
        .pinIn(firstPinIn),
        .analogMask(firstAnalogMask),
        .altSel(8'h00),
        .altOut(8'h00),
        .altOe(8'h00),
        .dir(firstDir),
        .latch(firstLatch),
        .pinOut(firstPinOut),
        .pinOe(firstPinOe),
        .pinLevel(firstLevel),
        .readValue(firstRead)
    );

    gpio_port_slice secondPort (
        .clk(clk),
        .reset(reset),
        .dirWrite(regWrite && hitSecondDir),
        .latchWrite(regWrite && hitSecondData),
        .wrData(regWrData),
        .pinIn(secondPinIn),
        .analogMask(secondAnalogMask),
        .altSel(secondAltSel),
        .altOut(secondAltOut),
        .altOe(secondAltOe),
        .dir(secondDir),
        .latch(secondLatch),
        .pinOut(secondPinOut),
        .pinOe(secondPinOe),
        .pinLevel(secondLevel),
        .readValue(secondRead)
    );

    gpio_port_slice thirdPort (
        .clk(clk),
        .reset(reset),
        .dirWrite(regWrite && hitThirdDir),
        .latchWrite(regWrite && hitThirdData),
        .wrData(regWrData),
        .pinIn(thirdPinIn),
        .analogMask(thirdAnalogMask),
        .altSel(8'h00),
        .altOut(8'h00),
        .altOe(8'h00),
        .dir(thirdDir),
        .latch(thirdLatch),
        .pinOut(thirdPinOut),
        .pinOe(thirdPinOe),
        .pinLevel(thirdLevel),
        .readValue(thirdRead)
    );

    // inputs stay visible to their units even while driven as outputs
    assign thirdCaptureInput = secondLevel[CAPTURE_BIT];
    assign serialDataIn = secondLevel[SERIAL_RX_BIT];
    assign serialClkIn = secondLevel[SERIAL_TX_BIT];

    ////////////////////////////////////////////////////////////////////////
    // read data, registered and held until the next read
    logic [7:0] rdData_reg, rdData_next;

    always_comb begin
        rdData_next = rdData_reg;
        if (regRead) begin
            rdData_next = READ_UNMAPPED;
            if (hitFirstDir) begin
                rdData_next = firstDir;
            end
            if (hitFirstData) begin
                rdData_next = firstRead;
            end
            if (hitSecondDir) begin
                rdData_next = secondDir;
            end
            if (hitSecondData) begin
                rdData_next = secondRead;
            end
            if (hitCfg) begin
                rdData_next = analogCfg_reg;
            end
            if (hitThirdDir) begin
                rdData_next = thirdDir;
            end
            if (hitThirdData) begin
                rdData_next = thirdRead;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdData_reg <= READ_UNMAPPED;
        end else begin
            rdData_reg <= rdData_next;
        end
    end

    assign regRdData = rdData_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence cfgWriteDigital;
        regWrite && hitCfg &&
        regWrData[PIN_CFG_HI:PIN_CFG_LO] == PIN_CFG_ALL_DIGITAL;
    endsequence

    sequence latchWriteOutput;
        regWrite && hitFirstData ##1 1'b1;
    endsequence

    AST_CFG_BIT4_ZERO: assert property (@(posedge clk) disable iff (reset)
        regRead && hitCfg |=> regRdData[4] == 1'b0)
        else $error("analog config bit 4 read back non-zero");
    AST_RESET_ANALOG: assert property (@(posedge clk)
        $fell(reset) && !vrefLowEnable && !vrefHighEnable |->
        secondAnalogMask[3:0] == 4'hf && thirdAnalogMask == 8'hf0 &&
        firstAnalogMask == 8'hff)
        else $error("shared pins not analog after reset");
    AST_DIGITAL_AFTER_CFG: assert property (@(posedge clk)
        disable iff (reset)
        cfgWriteDigital |=> firstAnalogMask == 8'h00 &&
        thirdAnalogMask == 8'h00)
        else $error("pins stay analog after digital select");
    AST_THIRD_LOW_DIGITAL: assert property (@(posedge clk)
        disable iff (reset) thirdAnalogMask[3:0] == 4'h0)
        else $error("third port low nibble became analog");
    AST_SECOND_REVERSED: assert property (@(posedge clk)
        disable iff (reset)
        !vrefLowEnable && !vrefHighEnable && pinConfigField == 4'hd |->
        secondAnalogMask[3:0] == 4'he)
        else $error("second port channel order not reversed");
    AST_FIRST_ORDER: assert property (@(posedge clk) disable iff (reset)
        pinConfigField == 4'h7 |-> firstAnalogMask == 8'h1f)
        else $error("first port channel order wrong");
    AST_VREF_LOW: assert property (@(posedge clk) disable iff (reset)
        vrefLowEnable |-> secondAnalogMask[VREF_LOW_BIT] &&
        !secondPinOe[VREF_LOW_BIT])
        else $error("low reference pin still digital");
    AST_ANALOG_READS_ZERO: assert property (@(posedge clk)
        disable iff (reset)
        regRead && hitFirstData ##1 1'b1 |->
        (regRdData & $past(firstAnalogMask)) == 8'h00)
        else $error("analog pin read back non-zero");
    AST_OUTPUT_FOLLOWS_LATCH: assert property (@(posedge clk)
        disable iff (reset)
        latchWriteOutput |-> firstLatch == $past(regWrData) &&
        (firstPinOut & ~firstDir) == (firstLatch & ~firstDir) &&
        firstPinOe == (~firstDir & ~firstAnalogMask))
        else $error("output pin not driven from latch");
    AST_PULSE_OVERRIDE: assert property (@(posedge clk)
        disable iff (reset)
        pulseEnable |-> secondPinOut[PWM_BIT] == thirdPulseOutput)
        else $error("pulse output not on its pin");
    AST_SERIAL_CLOCK: assert property (@(posedge clk) disable iff (reset)
        serialEnable |-> secondPinOe[SERIAL_TX_BIT] == serialClkOe &&
        secondPinOut[SERIAL_TX_BIT] == serialClkOut)
        else $error("serial clock pin not handed over");
    AST_DIR_INPUT: assert property (@(posedge clk) disable iff (reset)
        thirdDir[0] |-> !thirdPinOe[0])
        else $error("input pin is being driven");
    AST_READ_PIN: assert property (@(posedge clk) disable iff (reset)
        regRead && hitThirdData && thirdAnalogMask == 8'h00 |=>
        regRdData == $past(thirdLevel))
        else $error("port read did not return pin levels");
endmodule

// >>> common/gpio_ports_pkg.sv
// constants for the three shared analog / digital ports
// assumes banked byte-wide register access on the system clock
package gpio_ports_pkg;

    ////////////////////////////////////////////////////////////////////////
    // bank numbers and register offsets inside a bank
    localparam logic [3:0] BANK_LOW_PORTS = 4'h5;
    localparam logic [3:0] BANK_HIGH_PORT = 4'h8;
    localparam logic [7:0] OFS_FIRST_DIR = 8'h10;
    localparam logic [7:0] OFS_FIRST_DATA = 8'h11;
    localparam logic [7:0] OFS_SECOND_DIR = 8'h12;
    localparam logic [7:0] OFS_SECOND_DATA = 8'h13;
    localparam logic [7:0] OFS_ANALOG_CFG = 8'h15;
    localparam logic [7:0] OFS_THIRD_DIR = 8'h10;
    localparam logic [7:0] OFS_THIRD_DATA = 8'h11;

    ////////////////////////////////////////////////////////////////////////
    // reset values and the implemented analog config bit mask
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] ANALOG_CFG_RESET = 8'h00;
    localparam logic [7:0] ANALOG_CFG_IMPL = 8'hef;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // analog_pin_config fields
    localparam int CLK_SEL_HI = 7;
    localparam int CLK_SEL_LO = 6;
    localparam int RESULT_FMT_BIT = 5;
    localparam int PIN_CFG_HI = 3;
    localparam int PIN_CFG_LO = 0;
    localparam logic [3:0] PIN_CFG_ALL_DIGITAL = 4'he;

    ////////////////////////////////////////////////////////////////////////
    // converter channel layout on the pins
    localparam logic [4:0] CHANNEL_COUNT = 5'h10;
    localparam int FIRST_BASE_CH = 4;
    localparam int SECOND_TOP_CH = 3;
    localparam int THIRD_BASE_CH = 12;

    ////////////////////////////////////////////////////////////////////////
    // second port bit positions of shared functions
    localparam int VREF_LOW_BIT = 2;
    localparam int VREF_HIGH_BIT = 3;
    localparam int CAPTURE_BIT = 4;
    localparam int PWM_BIT = 5;
    localparam int SERIAL_RX_BIT = 6;
    localparam int SERIAL_TX_BIT = 7;

endpackage

// >>> logic/analog_channel_map.sv
// decodes pin_config_field into per-port analog masks
// assumes a static field; purely combinational
`timescale 1ns/100ps
module analog_channel_map
    import gpio_ports_pkg::*;
(
    input wire logic [3:0] pinConfigField,
    input wire logic vrefLowEnable,
    input wire logic vrefHighEnable,
    output logic [7:0] firstAnalog,
    output logic [7:0] secondAnalog,
    output logic [7:0] thirdAnalog
);
    logic [15:0] chanAnalog;
    logic [4:0] analogLimit;

    // field n leaves channels 0..15-n analog; 0xe/0xf make all digital
    always_comb begin
        analogLimit = CHANNEL_COUNT - {1'b0, pinConfigField};
        chanAnalog = '0;
        for (int c = 0; c < 16; c++) begin
            if (pinConfigField < PIN_CFG_ALL_DIGITAL &&
                5'(c) < analogLimit) begin
                chanAnalog[c] = 1'b1;
            end
        end
        secondAnalog = '0;
        thirdAnalog = '0;
        for (int i = 0; i < 8; i++) begin
            firstAnalog[i] = chanAnalog[FIRST_BASE_CH + i];
        end
        for (int i = 0; i < 4; i++) begin
            secondAnalog[i] = chanAnalog[SECOND_TOP_CH - i];
            thirdAnalog[4 + i] = chanAnalog[THIRD_BASE_CH + i];
        end
        // reference inputs take the pin away from digital use
        secondAnalog[VREF_LOW_BIT] = secondAnalog[VREF_LOW_BIT] |
                                     vrefLowEnable;
        secondAnalog[VREF_HIGH_BIT] = secondAnalog[VREF_HIGH_BIT] |
                                      vrefHighEnable;
    end
endmodule

// >>> logic/gpio_port_slice.sv
// one 8-bit port: direction, output latch, pin synchroniser
// assumes pins asynchronous to clk; alternate functions from outside
`timescale 1ns/100ps
module gpio_port_slice
    import gpio_ports_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic dirWrite,
    input wire logic latchWrite,
    input wire logic [7:0] wrData,
    input wire logic [7:0] pinIn,
    input wire logic [7:0] analogMask,
    input wire logic [7:0] altSel,
    input wire logic [7:0] altOut,
    input wire logic [7:0] altOe,
    output logic [7:0] dir,
    output logic [7:0] latch,
    output logic [7:0] pinOut,
    output logic [7:0] pinOe,
    output logic [7:0] pinLevel,
    output logic [7:0] readValue
);
    logic [7:0] dir_reg, dir_next;
    logic [7:0] latch_reg, latch_next;
    logic [7:0] syncA_reg, syncB_reg;

    always_comb begin
        dir_next = dirWrite ? wrData : dir_reg;
        latch_next = latchWrite ? wrData : latch_reg;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            dir_reg <= DIR_RESET;
            latch_reg <= LATCH_RESET;
        end else begin
            dir_reg <= dir_next;
            latch_reg <= latch_next;
        end
    end

    // data path only, no reset needed
    always_ff @(posedge clk) begin
        syncA_reg <= pinIn;
        syncB_reg <= syncA_reg;
    end

    assign dir = dir_reg;
    assign latch = latch_reg;
    assign pinLevel = syncB_reg;
    // 1 = input, 0 = driven from latch; altSel bits follow altOut/altOe instead, even where analogMask is set
    assign pinOut = (altSel & altOut) | (~altSel & latch_reg);
    assign pinOe = (altSel & altOe) |
                   (~altSel & ~dir_reg & ~analogMask);
    assign readValue = syncB_reg & ~analogMask;

    AST_LATCH_ONLY: assert property (@(posedge clk) disable iff (reset)
        latchWrite |=> latch == $past(wrData) && $stable(dir))
        else $error("latch write did not land or touched direction");
    AST_DIR_RESET: assert property (@(posedge clk)
        $fell(reset) |-> dir == DIR_RESET && pinOe == (altSel & altOe))
        else $error("direction not all inputs after reset");
endmodule

// >>> tb/testbench.sv
// self-checking bench for the three shared analog / digital ports
// assumes the design's package and a 200 MHz clock; drives pins directly
`timescale 1ns/100ps
module testbench;
    import gpio_ports_pkg::*;

    logic clk, reset, regWrite, regRead;
    logic [3:0] bankSelect;
    logic [7:0] regAddr, regWrData, regRdData;
    logic [2:0][7:0] pinIn, pinOut, pinOe, anaMask;
    logic vrefLowEnable, vrefHighEnable, resultFormat, thirdCaptureInput;
    logic [1:0] conversionClockSelect;
    logic pulseEnable, thirdPulseOutput, serialEnable, serialDataOut;
    logic serialDataOe, serialClkOut, serialClkOe, serialDataIn, serialClkIn;
    int badCount, nCompared;
    logic [7:0] dirM [3];
    logic [7:0] latM [3];
    logic [7:0] cfgM;
    logic [3:0] bankOf [3] = '{BANK_LOW_PORTS, BANK_LOW_PORTS, BANK_HIGH_PORT};
    logic [7:0] dirOf [3] = '{OFS_FIRST_DIR, OFS_SECOND_DIR, OFS_THIRD_DIR};
    logic [7:0] datOf [3] = '{OFS_FIRST_DATA, OFS_SECOND_DATA, OFS_THIRD_DATA};

    analog_shared_gpio_ports DUT (.clk(clk), .reset(reset),
        .bankSelect(bankSelect), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData),
        .firstPinIn(pinIn[0]), .firstPinOut(pinOut[0]),
        .firstPinOe(pinOe[0]), .secondPinIn(pinIn[1]),
        .secondPinOut(pinOut[1]), .secondPinOe(pinOe[1]),
        .thirdPinIn(pinIn[2]), .thirdPinOut(pinOut[2]),
        .thirdPinOe(pinOe[2]), .vrefLowEnable(vrefLowEnable),
        .vrefHighEnable(vrefHighEnable),
        .conversionClockSelect(conversionClockSelect),
        .resultFormat(resultFormat), .firstAnalogMask(anaMask[0]),
        .secondAnalogMask(anaMask[1]), .thirdAnalogMask(anaMask[2]),
        .thirdCaptureInput(thirdCaptureInput), .pulseEnable(pulseEnable),
        .thirdPulseOutput(thirdPulseOutput), .serialEnable(serialEnable),
        .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
        .serialClkOut(serialClkOut), .serialClkOe(serialClkOe),
        .serialDataIn(serialDataIn), .serialClkIn(serialClkIn));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // reference model
    function automatic logic [7:0] amask(int p);
        logic [7:0] m;
        int n;
        m = 8'h00;
        n = int'(cfgM[3:0]);
        for (int c = 0; c < 16; c++) begin
            if (n < 14 && c <= 15 - n) begin
                if (p == 0 && c >= 4 && c < 12) m[c-4] = 1'b1;
                if (p == 1 && c < 4) m[3-c] = 1'b1;
                if (p == 2 && c >= 12) m[c-8] = 1'b1;
            end
        end
        if (p == 1) begin
            m[2] = m[2] | vrefLowEnable;
            m[3] = m[3] | vrefHighEnable;
        end
        return m;
    endfunction

    function automatic logic [7:0] rdExp(logic [3:0] b, logic [7:0] a);
        for (int p = 0; p < 3; p++) begin
            if (b == bankOf[p] && a == dirOf[p]) return dirM[p];
            if (b == bankOf[p] && a == datOf[p]) return pinIn[p] & ~amask(p);
        end
        if (b == BANK_LOW_PORTS && a == OFS_ANALOG_CFG) return cfgM;
        return READ_UNMAPPED;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus tasks and comparisons
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        nCompared++;
        if (got !== exp) begin
            badCount++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] b, input logic [7:0] a,
                      input logic [7:0] d);
        bankSelect = b;
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(posedge clk);
        #1;
        regWrite = 1'b0;
        for (int p = 0; p < 3; p++) begin
            if (b == bankOf[p] && a == dirOf[p]) dirM[p] = d;
            if (b == bankOf[p] && a == datOf[p]) latM[p] = d;
        end
        if (b == BANK_LOW_PORTS && a == OFS_ANALOG_CFG) cfgM = d & 8'hef;
        // idle edge so the next strobe is not raised in the same step
        @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [3:0] b, input logic [7:0] a);
        logic [7:0] e;
        e = rdExp(b, a);
        bankSelect = b;
        regAddr = a;
        regRead = 1'b1;
        @(posedge clk);
        #1;
        regRead = 1'b0;
        check(regRdData, e);
        @(posedge clk);
        #1;
    endtask

    task automatic chkPins();
        logic [7:0] oe, out, m;
        for (int p = 0; p < 3; p++) begin
            m = amask(p);
            oe = ~dirM[p] & ~m;
            out = latM[p];
            if (p == 1 && pulseEnable) out[PWM_BIT] = thirdPulseOutput;
            if (p == 1 && serialEnable) begin
                oe[SERIAL_RX_BIT] = serialDataOe;
                out[SERIAL_RX_BIT] = serialDataOut;
                oe[SERIAL_TX_BIT] = serialClkOe;
                out[SERIAL_TX_BIT] = serialClkOut;
            end
            check(pinOe[p], oe);
            check(pinOut[p] & oe, out & oe);
            check(anaMask[p], m);
        end
        check({7'h00, thirdCaptureInput}, {7'h00, pinIn[1][4]});
        check({6'h00, serialDataIn, serialClkIn},
              {6'h00, pinIn[1][6], pinIn[1][7]});
        check({5'h00, conversionClockSelect, resultFormat},
              {5'h00, cfgM[7:5]});
    endtask

    task automatic rdAll();
        for (int p = 0; p < 3; p++) begin
            rd(bankOf[p], dirOf[p]);
            rd(bankOf[p], datOf[p]);
        end
        rd(BANK_LOW_PORTS, OFS_ANALOG_CFG);
    endtask

    // reset also drops the alternate owners so reset pin state is visible
    task automatic resetChk();
        reset = 1'b1;
        pulseEnable = 1'b0;
        serialEnable = 1'b0;
        vrefLowEnable = 1'b0;
        vrefHighEnable = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        reset = 1'b0;
        dirM = '{DIR_RESET, DIR_RESET, DIR_RESET};
        latM = '{LATCH_RESET, LATCH_RESET, LATCH_RESET};
        cfgM = ANALOG_CFG_RESET;
        chkPins();
        rdAll();
    endtask

    task automatic testDone();
        $display("compared %0d, errors %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [7:0] d;
        badCount = 0;
        nCompared = 0;
        {regWrite, regRead, bankSelect, regAddr, regWrData} = '0;
        {thirdPulseOutput, serialDataOut, serialDataOe} = '0;
        {serialClkOut, serialClkOe} = '0;
        pinIn = '0;
        d = 8'($urandom(22));
        resetChk();
        for (int i = 0; i < 32; i++) begin
            d = 8'($urandom);
            d[3:0] = i[3:0];
            wr(BANK_LOW_PORTS, OFS_ANALOG_CFG, d);
            for (int p = 0; p < 3; p++) begin
                wr(bankOf[p], dirOf[p], 8'($urandom));
                wr(bankOf[p], datOf[p], 8'($urandom));
            end
            pinIn = 24'($urandom);
            {pulseEnable, serialEnable, thirdPulseOutput} = 3'($urandom);
            {serialDataOut, serialDataOe, serialClkOut} = 3'($urandom);
            {serialClkOe, vrefLowEnable, vrefHighEnable} = 3'($urandom);
            // two-stage pin synchroniser needs the extra edges
            repeat (3) @(posedge clk);
            #1;
            chkPins();
            rdAll();
        end
        // bring-up order: all digital, clear latches, then directions
        d = {4'h0, PIN_CFG_ALL_DIGITAL};
        wr(BANK_LOW_PORTS, OFS_ANALOG_CFG, d);
        for (int p = 0; p < 3; p++) begin
            wr(bankOf[p], datOf[p], 8'h00);
            wr(bankOf[p], dirOf[p], 8'h03);
        end
        chkPins();
        rdAll();
        // unmapped places read zero and ignore writes
        wr(4'h3, OFS_FIRST_DIR, 8'h00);
        wr(BANK_HIGH_PORT, OFS_ANALOG_CFG, 8'h3e);
        rd(4'h3, OFS_FIRST_DIR);
        rd(BANK_HIGH_PORT, OFS_ANALOG_CFG);
        rd(BANK_HIGH_PORT, OFS_SECOND_DATA);
        rd(BANK_LOW_PORTS, 8'h14);
        rdAll();
        resetChk();
        testDone();
    end

    initial begin
        repeat (5000) @(posedge clk);
        badCount++;
        $display("Error at %0t: run did not finish in time", $time);
        testDone();
    end
endmodule
